// ### bench/dtcu_asserts.sv
// Checker for the dual timer unit: APB handshake, read data and flag clearing.
// Assumes it is bound to dtcu_timer_unit and sees only its ports.
`timescale 1ns/1ns
module dtcu_asserts
    import dtcu_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Flags
    input wire logic        vec_ack_zero,
    input wire logic        vec_ack_one,
    input wire logic        overflow_flag_zero,
    input wire logic        overflow_flag_one
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = psel && penable && pready && !pwrite;
    wire run_wr  = psel && penable && pready && pwrite && paddr == 12'h220;

    chk_ready_access: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    chk_ready_setup: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_rdata_upper: assert property (rd_done |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_align_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    chk_mapped_ok: assert property (pready && paddr[1:0] == 2'h0
        && paddr inside {[12'h220:12'h238]} |-> !pslverr)
        else $error("mapped access refused");
    chk_clkctl_low: assert property (rd_done && paddr == 12'h238 |-> prdata[2:0] == 3'h0)
        else $error("clock control low bits not zero");
    chk_flag0_clear: assert property ($fell(overflow_flag_zero) |->
        $past(vec_ack_zero) || $past(run_wr))
        else $error("timer 0 flag cleared without cause");
    chk_flag1_clear: assert property ($fell(overflow_flag_one) |->
        $past(vec_ack_one) || $past(run_wr))
        else $error("timer 1 flag cleared without cause");
endmodule // dtcu_asserts

bind dtcu_timer_unit dtcu_asserts dtcu_asserts_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vec_ack_zero(vec_ack_zero), .vec_ack_one(vec_ack_one),
    .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one)
);

// ### bench/dtcu_pin_model.sv
// Model of the external timer pins: gate levels and count pulses.
// Assumes pins idle high, as on a pulled-up port.
`timescale 1ns/1ns
module dtcu_pin_model
    import dtcu_pkg::*;
(
    // Clock
    input  wire logic pclk,
    // Pins
    output dtcu_pins_t pins
);
    initial pins = '1;

    // Gate level of timer t
    task automatic gate(input int t, input logic lvl);
        @(posedge pclk);
        pins[2 + t] <= lvl;
    endtask

    // Falling edges on the count pin of timer t, levels held several cycles
    task automatic pulse(input int t, input int n);
        repeat (n) begin
            @(posedge pclk);
            pins[t] <= 1'b0;
            repeat (4) @(posedge pclk);
            pins[t] <= 1'b1;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule // dtcu_pin_model

// ### bench/tb.sv
// Self-checking bench for the dual timer unit over APB.
// Assumes the pin model drives the pins; each read yields one queued result.
`timescale 1ns/1ns
module tb
    import dtcu_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  ack = 2'h0;
    logic [1:0]  ovf;
    dtcu_pins_t  pins;
    logic [32:0] expq[$];
    logic [7:0]  r;
    int          miscompares = 0;
    int          n_tests = 0;

    always #50 pclk = ~pclk;

    dtcu_pin_model dtcu_pin_model_i (.pclk(pclk), .pins(pins));
    dtcu_timer_unit dtcu_timer_unit_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .vec_ack_zero(ack[0]), .vec_ack_one(ack[1]),
        .overflow_flag_zero(ovf[0]), .overflow_flag_one(ovf[1])
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
        expq.push_back({err, 24'h000000, e});
        xfer(a, 1'b0, 8'h00);
    endtask

    task automatic clr();
        for (int i = 0; i < 4; i++) wr(12'h228 + 12'(4 * i), 8'h00);
    endtask

    // Run for exactly 120 cycles, a whole number of both prescale periods
    task automatic window(input logic [7:0] run);
        wr(12'h220, run);
        repeat (117) @(posedge pclk);
        wr(12'h220, 8'h00);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            check({pslverr, prdata}, expq.pop_front());
        end
    end

    initial begin
        repeat (10000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = 8'($urandom(70492));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(12'h220 + 12'(4 * i), 8'h00);
        rd(12'h23C, 8'h00, 1'b1);
        rd(12'h221, 8'h00, 1'b1);
        wr(12'h238, 8'hFF);
        rd(12'h238, 8'hF8);
        r = 8'($urandom);
        wr(12'h224, r);
        rd(12'h224, r);
        r = 8'($urandom);
        wr(12'h230, r);
        rd(12'h230, r);
        wr(12'h220, 8'hA0);
        rd(12'h220, 8'hA0);
        wr(12'h220, 8'h00);
        wr(12'h224, 8'h11);
        for (int k = 0; k < 2; k++) begin
            clr();
            wr(12'h238, k ? 8'h08 : 8'h10);
            window(8'h50);
            rd(12'h228, k ? 8'h1E : 8'h0A);
            rd(12'h22C, k ? 8'h0A : 8'h1E);
        end
        wr(12'h224, 8'hDD);
        clr();
        wr(12'h220, 8'h50);
        for (int t = 0; t < 2; t++) begin
            dtcu_pin_model_i.gate(t, 1'b0);
            dtcu_pin_model_i.pulse(t, 2);
            dtcu_pin_model_i.gate(t, 1'b1);
            dtcu_pin_model_i.pulse(t, 3 + t);
            rd(12'h228 + 12'(4 * t), 8'(3 + t));
        end
        wr(12'h220, 8'h00);
        dtcu_pin_model_i.pulse(0, 2);
        rd(12'h228, 8'h03);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                wr(12'h224, 8'(4 + m) << (4 * t));
                wr(12'h230 + 12'(4 * t), m == 2 ? 8'hA5 : 8'hFF);
                wr(12'h228 + 12'(4 * t), 8'hFF);
                wr(12'h220, 8'h10 << (2 * t));
                dtcu_pin_model_i.pulse(t, 1);
                rd(12'h228 + 12'(4 * t), m == 0 ? 8'hE0 : (m == 1 ? 8'h00 : 8'hA5));
                rd(12'h230 + 12'(4 * t), m == 2 ? 8'hA5 : 8'h00);
                rd(12'h220, 8'h30 << (2 * t));
                check(33'(ovf[t]), 33'h1);
                ack[t] <= 1'b1;
                @(posedge pclk);
                ack[t] <= 1'b0;
                rd(12'h220, 8'h10 << (2 * t));
                check(33'(ovf[t]), 33'h0);
            end
        end
        wr(12'h224, 8'h70);
        wr(12'h22C, 8'h33);
        wr(12'h220, 8'h40);
        dtcu_pin_model_i.pulse(1, 2);
        rd(12'h22C, 8'h33);
        wr(12'h220, 8'h00);
        wr(12'h238, 8'h00);
        wr(12'h224, 8'h07);
        clr();
        wr(12'h220, 8'h10);
        dtcu_pin_model_i.pulse(0, 2);
        window(8'h40);
        rd(12'h228, 8'h02);
        rd(12'h230, 8'h0A);
        @(posedge pclk);
        tally_and_finish();
    end
endmodule // tb

// ### common/dtcu_pkg.sv
// Constants and types shared by the dual timer/counter unit.
// Assumes pclk is the crystal clock and APB registers sit one per word.
package dtcu_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] DTCU_RUN_IDX   = 10'h088;
    localparam logic [9:0] DTCU_MODE_IDX  = 10'h089;
    localparam logic [9:0] DTCU_LO0_IDX   = 10'h08A;
    localparam logic [9:0] DTCU_LO1_IDX   = 10'h08B;
    localparam logic [9:0] DTCU_HI0_IDX   = 10'h08C;
    localparam logic [9:0] DTCU_HI1_IDX   = 10'h08D;
    localparam logic [9:0] DTCU_PRE_IDX   = 10'h08E;

    // Reset values
    localparam logic [7:0] DTCU_MODE_RST  = 8'h00;
    localparam logic [7:0] DTCU_COUNT_RST = 8'h00;
    localparam logic [4:0] DTCU_PRE_RST   = 5'h00;

    // Field positions
    localparam int DTCU_RUN_OVF1_BIT = 7;
    localparam int DTCU_RUN_RUN1_BIT = 6;
    localparam int DTCU_RUN_OVF0_BIT = 5;
    localparam int DTCU_RUN_RUN0_BIT = 4;
    localparam int DTCU_PRE_SEL1_BIT = 1;
    localparam int DTCU_PRE_SEL0_BIT = 0;
    localparam int DTCU_PRE_LSB      = 3;

    // Slow prescale divisor of the crystal clock; fast tick phase in the low two count bits
    localparam logic [3:0] DTCU_DIV_SLOW = 4'd12;
    localparam logic [1:0] DTCU_DIV_FAST = 2'd3;

    typedef enum logic [1:0] {
        DTCU_MODE_13BIT  = 2'b00,
        DTCU_MODE_16BIT  = 2'b01,
        DTCU_MODE_RELOAD = 2'b10,
        DTCU_MODE_SPLIT  = 2'b11
    } dtcu_mode_t;

    typedef struct packed {
        logic       gate;
        logic       counter_sel;
        dtcu_mode_t mode;
    } dtcu_tmode_t;

    typedef struct packed {
        logic gate_pin_one;
        logic gate_pin_zero;
        logic count_pin_one;
        logic count_pin_zero;
    } dtcu_pins_t;

endpackage

// ### logic/dtcu_pin_sync.sv
// Two-stage synchronisers for the timer pins and falling-edge pulses.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/1ns
module dtcu_pin_sync
    import dtcu_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pins
    input  dtcu_pins_t pins_async,
    // Synchronised levels and falling edges
    output dtcu_pins_t pins_level,
    output dtcu_pins_t pins_fall
);

    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [3:0] last_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff[gi] <= 1'b1;
                    sync_ff[gi] <= 1'b1;
                    last_ff[gi] <= 1'b1;
                end else begin
                    meta_ff[gi] <= pins_async[gi];
                    sync_ff[gi] <= meta_ff[gi];
                    last_ff[gi] <= sync_ff[gi];
                end
            end
        end
    endgenerate

    assign pins_level = dtcu_pins_t'(sync_ff);
    assign pins_fall  = dtcu_pins_t'(last_ff & ~sync_ff);

endmodule // dtcu_pin_sync

// ### logic/dtcu_prescale.sv
// Crystal prescaler: one-cycle ticks at crystal/12 and crystal/4.
// Assumes pclk is the crystal clock.
`timescale 1ns/1ns
module dtcu_prescale
    import dtcu_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Ticks
    output logic      tick_slow,
    output logic      tick_fast
);

    logic [3:0] div_cnt_ff;
    logic [3:0] nxt_div_cnt;

    assign nxt_div_cnt = (div_cnt_ff == DTCU_DIV_SLOW - 4'd1) ? 4'd0 : div_cnt_ff + 4'd1;
    assign tick_slow   = (div_cnt_ff == DTCU_DIV_SLOW - 4'd1);
    // Twelve is a multiple of four, so the low bits mark every fourth cycle
    assign tick_fast   = (div_cnt_ff[1:0] == DTCU_DIV_FAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 4'd0;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
        end
    end

endmodule // dtcu_prescale

// ### logic/dtcu_timer_unit.sv
// Dual 16-bit timer/counter unit with APB register access.
// Assumes pclk is the crystal clock and the interrupt controller pulses
// the vector acknowledges for one cycle.
`timescale 1ns/1ns

module dtcu_timer_unit
    import dtcu_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  dtcu_pins_t       pins,
    // Interrupt vector acknowledges
    input  wire logic        vec_ack_zero,
    input  wire logic        vec_ack_one,
    // Overflow flags
    output logic             overflow_flag_zero,
    output logic             overflow_flag_one
);

    ////////////////////////////////////////////////////////////////////////
    // Count step for modes 0 to 2; mode 3 returns the count unchanged

    function automatic logic [16:0] count_step(
        input dtcu_mode_t mode,
        input logic [7:0] low,
        input logic [7:0] high
    );
        logic [13:0] sum13;
        logic [16:0] sum16;
        logic [8:0]  sum8;
        sum13 = {1'b0, high, low[4:0]} + 14'h1;
        sum16 = {1'b0, high, low} + 17'h1;
        sum8  = {1'b0, low} + 9'h1;
        count_step = {1'b0, high, low};
        unique case (mode)
            DTCU_MODE_13BIT: begin
                count_step = {sum13[13], sum13[12:5], low[7:5], sum13[4:0]};
            end
            DTCU_MODE_16BIT: begin
                count_step = sum16;
            end
            DTCU_MODE_RELOAD: begin
                count_step = sum8[8] ? {1'b1, high, high} : {1'b0, high, sum8[7:0]};
            end
            DTCU_MODE_SPLIT: begin
                count_step = {1'b0, high, low};
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]  mode_ctl_ff;
    logic [7:0]  cnt_lo0_ff;
    logic [7:0]  cnt_hi0_ff;
    logic [7:0]  cnt_lo1_ff;
    logic [7:0]  cnt_hi1_ff;
    logic [4:0]  pre_ctl_ff;
    logic        run0_ff;
    logic        run1_ff;
    logic        ovf0_ff;
    logic        ovf1_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Pins and prescaler

    dtcu_pins_t pin_level;
    dtcu_pins_t pin_fall;
    logic       tick_slow;
    logic       tick_fast;

    dtcu_pin_sync u_pin_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pins_async (pins),
        .pins_level (pin_level),
        .pins_fall  (pin_fall)
    );

    dtcu_prescale u_prescale (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick_slow (tick_slow),
        .tick_fast (tick_fast)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [9:0] a_idx;
    logic       aligned;
    logic       setup;
    logic       wr_en;
    logic       hit_run;
    logic       hit_mode;
    logic       hit_lo0;
    logic       hit_lo1;
    logic       hit_hi0;
    logic       hit_hi1;
    logic       hit_pre;
    logic       hit_any;
    logic [7:0] wbyte;

    assign a_idx     = paddr[11:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign setup     = psel & ~penable;
    assign wr_en     = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    assign hit_run   = aligned & (a_idx == DTCU_RUN_IDX);
    assign hit_mode  = aligned & (a_idx == DTCU_MODE_IDX);
    assign hit_lo0   = aligned & (a_idx == DTCU_LO0_IDX);
    assign hit_lo1   = aligned & (a_idx == DTCU_LO1_IDX);
    assign hit_hi0   = aligned & (a_idx == DTCU_HI0_IDX);
    assign hit_hi1   = aligned & (a_idx == DTCU_HI1_IDX);
    assign hit_pre   = aligned & (a_idx == DTCU_PRE_IDX);
    assign hit_any   = hit_run | hit_mode | hit_lo0 | hit_lo1 | hit_hi0 | hit_hi1 | hit_pre;
    assign wbyte     = pwdata[7:0];

    logic [7:0] run_view;
    logic [7:0] pre_view;
    logic [7:0] rd_byte;

    assign run_view   = {ovf1_ff, run1_ff, ovf0_ff, run0_ff, 4'h0};
    assign pre_view   = {pre_ctl_ff, 3'h0};
    assign rd_byte    = hit_run  ? run_view    :
                        hit_mode ? mode_ctl_ff :
                        hit_lo0  ? cnt_lo0_ff  :
                        hit_lo1  ? cnt_lo1_ff  :
                        hit_hi0  ? cnt_hi0_ff  :
                        hit_hi1  ? cnt_hi1_ff  :
                        hit_pre  ? pre_view    : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Count enables

    dtcu_tmode_t mode0;
    dtcu_tmode_t mode1;
    logic        split0;
    logic        pre0;
    logic        pre1;
    logic        clk0;
    logic        clk1;
    logic        gate0_ok;
    logic        gate1_ok;
    logic        inc0;
    logic        inc1;
    logic        inc0_high;

    assign mode0    = dtcu_tmode_t'(mode_ctl_ff[3:0]);
    assign mode1    = dtcu_tmode_t'(mode_ctl_ff[7:4]);
    assign split0   = (mode0.mode == DTCU_MODE_SPLIT);
    assign pre0     = pre_ctl_ff[DTCU_PRE_SEL0_BIT] ? tick_fast : tick_slow;
    assign pre1     = pre_ctl_ff[DTCU_PRE_SEL1_BIT] ? tick_fast : tick_slow;
    assign clk0     = mode0.counter_sel ? pin_fall.count_pin_zero : pre0;
    assign clk1     = mode1.counter_sel ? pin_fall.count_pin_one : pre1;
    assign gate0_ok = ~mode0.gate | pin_level.gate_pin_zero;
    assign gate1_ok = ~mode1.gate | pin_level.gate_pin_one;
    assign inc0     = run0_ff & gate0_ok & clk0;
    // With timer 0 split, timer 1 run control belongs to the timer 0 high byte
    assign inc1     = (split0 | run1_ff) & gate1_ok & clk1 &
                      (mode1.mode != DTCU_MODE_SPLIT);
    assign inc0_high = split0 & run1_ff & pre0;

    ////////////////////////////////////////////////////////////////////////
    // Next count values

    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  split_low;
    logic [8:0]  split_high;
    logic [7:0]  nxt_cnt_lo0;
    logic [7:0]  nxt_cnt_hi0;
    logic [7:0]  nxt_cnt_lo1;
    logic [7:0]  nxt_cnt_hi1;
    logic        ovf0_evt;
    logic        ovf1_evt;

    assign step0      = count_step(mode0.mode, cnt_lo0_ff, cnt_hi0_ff);
    assign step1      = count_step(mode1.mode, cnt_lo1_ff, cnt_hi1_ff);
    assign split_low  = {1'b0, cnt_lo0_ff} + 9'h1;
    assign split_high = {1'b0, cnt_hi0_ff} + 9'h1;

    always_comb begin
        nxt_cnt_lo0 = cnt_lo0_ff;
        nxt_cnt_hi0 = cnt_hi0_ff;
        nxt_cnt_lo1 = cnt_lo1_ff;
        nxt_cnt_hi1 = cnt_hi1_ff;
        ovf0_evt    = 1'b0;
        ovf1_evt    = 1'b0;
        if (split0) begin
            if (inc0) begin
                nxt_cnt_lo0 = split_low[7:0];
                ovf0_evt    = split_low[8];
            end
            if (inc0_high) begin
                nxt_cnt_hi0 = split_high[7:0];
                ovf1_evt    = split_high[8];
            end
        end else if (inc0) begin
            {nxt_cnt_hi0, nxt_cnt_lo0} = step0[15:0];
            ovf0_evt                   = step0[16];
        end
        if (inc1) begin
            {nxt_cnt_hi1, nxt_cnt_lo1} = step1[15:0];
            ovf1_evt                   = ovf1_evt | (step1[16] & ~split0);
        end
        // Software writes win over counting in the same cycle
        if (wr_en & hit_lo0) begin
            nxt_cnt_lo0 = wbyte;
        end
        if (wr_en & hit_hi0) begin
            nxt_cnt_hi0 = wbyte;
        end
        if (wr_en & hit_lo1) begin
            nxt_cnt_lo1 = wbyte;
        end
        if (wr_en & hit_hi1) begin
            nxt_cnt_hi1 = wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags and run controls

    logic wr_run;
    logic nxt_ovf0;
    logic nxt_ovf1;
    logic clr0;
    logic clr1;

    assign wr_run   = wr_en & hit_run;
    assign clr0     = vec_ack_zero | (wr_run & ~wbyte[DTCU_RUN_OVF0_BIT]);
    assign clr1     = vec_ack_one | (wr_run & ~wbyte[DTCU_RUN_OVF1_BIT]);
    // Overflow in the clearing cycle is kept
    assign nxt_ovf0 = ovf0_evt | (wr_run & wbyte[DTCU_RUN_OVF0_BIT]) |
                      (ovf0_ff & ~clr0);
    assign nxt_ovf1 = ovf1_evt | (wr_run & wbyte[DTCU_RUN_OVF1_BIT]) |
                      (ovf1_ff & ~clr1);

    ////////////////////////////////////////////////////////////////////////
    // State

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_lo0_ff <= DTCU_COUNT_RST;
            cnt_hi0_ff <= DTCU_COUNT_RST;
            cnt_lo1_ff <= DTCU_COUNT_RST;
            cnt_hi1_ff <= DTCU_COUNT_RST;
        end else begin
            cnt_lo0_ff <= nxt_cnt_lo0;
            cnt_hi0_ff <= nxt_cnt_hi0;
            cnt_lo1_ff <= nxt_cnt_lo1;
            cnt_hi1_ff <= nxt_cnt_hi1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctl_ff <= DTCU_MODE_RST;
            pre_ctl_ff  <= DTCU_PRE_RST;
            run0_ff     <= 1'b0;
            run1_ff     <= 1'b0;
        end else begin
            if (wr_en & hit_mode) begin
                mode_ctl_ff <= wbyte;
            end
            if (wr_en & hit_pre) begin
                pre_ctl_ff <= wbyte[7:DTCU_PRE_LSB];
            end
            if (wr_run) begin
                run0_ff <= wbyte[DTCU_RUN_RUN0_BIT];
                run1_ff <= wbyte[DTCU_RUN_RUN1_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf0_ff <= 1'b0;
            ovf1_ff <= 1'b0;
        end else begin
            ovf0_ff <= nxt_ovf0;
            ovf1_ff <= nxt_ovf1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: zero wait states, read data captured in the setup cycle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~hit_any;
            if (setup & ~pwrite) begin
                prdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign overflow_flag_zero = ovf0_ff;
    assign overflow_flag_one  = ovf1_ff;

endmodule // dtcu_timer_unit
